// *** verilog/arso_top.sv ***
// Serial result framer of a sigma-delta converter, with its control and
// status registers on an AXI4-Lite slave port.
// Assumes aclk is the master clock, results arrive as one-cycle strobes
// no faster than one frame time apart, and all inputs are synchronous.
//
// Function
// - The block is the link master and drives frame sync, shift clock and data.
// - The shift clock runs at half the master clock rate.
// - Frame sync is held low for exactly 32 shift clocks per result.
// - Data changes on the rising shift clock edge; the host samples on falling.
// - A frame holds 24 data bits, five status bits and three zeros, in order.
// - Final byte bits 7..3 hold settled, overrange, economy and two ratio bits.
// - The settled flag stays low after reset or restart for the settling time.
// - The settled flag reads zero in the frame while the overrange alert is raised; the status register bit is not masked.
// - The economy flag is one in each frame while low power mode is on.
// - Ratio bits read 01 for 64x, 00 for 256x, and 1x for 128x.
// - Software sets the amplifier-off bit; the amplifier is off while set.
// - The 24 data bits are carried in two's complement form.
// - The overrange flag is set per result if any of its samples overran.
`timescale 1ns/10ps
`include "arso_defines.svh"

module arso_top #(
	parameter int SETTLE_N64  = `ARSO_SETTLE_N64,
	parameter int SETTLE_N128 = `ARSO_SETTLE_N128,
	parameter int SETTLE_N256 = `ARSO_SETTLE_N256,
	parameter int SETTLE_L64  = `ARSO_SETTLE_L64,
	parameter int SETTLE_L128 = `ARSO_SETTLE_L128,
	parameter int SETTLE_L256 = `ARSO_SETTLE_L256,
	parameter int TIMER_W     = 16
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave.
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Filter side.
	input  wire logic        result_valid,
	input  wire logic [23:0] result_data,
	input  wire logic        sample_over,
	input  wire logic        filter_restart_n,
	// Control outputs to the analog and filter sections.
	output logic             front_amp_disable,
	output logic             economy_mode,
	output logic             ratio_sel_hi,
	output logic             ratio_sel_lo,
	// Serial link.
	output logic             shift_clock_out,
	output logic             frame_sync_out,
	output logic             tx_bit_line
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	localparam int MAX_SETTLE = (1 << TIMER_W) - 1;

	if (SETTLE_N64 > MAX_SETTLE || SETTLE_N128 > MAX_SETTLE ||
	    SETTLE_N256 > MAX_SETTLE || SETTLE_L64 > MAX_SETTLE ||
	    SETTLE_L128 > MAX_SETTLE || SETTLE_L256 > MAX_SETTLE) begin : g_chk
		$error("arso_top: settling count does not fit TIMER_W");
	end
	if (`ARSO_DATA_BITS + `ARSO_STATUS_BITS + `ARSO_PAD_BITS !=
	    `ARSO_FRAME_BITS) begin : g_chk_frame
		$error("arso_top: frame fields do not fill the frame");
	end

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Settling time for a ratio and power mode; any ratio with the upper
	// bit set counts as 128x.
	function automatic logic [TIMER_W-1:0] settle_limit(
		input logic       low_power,
		input logic [1:0] ratio
	);
		logic [TIMER_W-1:0] lim;
		lim = '0;
		case (arso_pkg::arso_ratio_t'(ratio))
			arso_pkg::ARSO_RATIO_64:
				lim = low_power ? TIMER_W'(SETTLE_L64) : TIMER_W'(SETTLE_N64);
			arso_pkg::ARSO_RATIO_256:
				lim = low_power ? TIMER_W'(SETTLE_L256) :
				                  TIMER_W'(SETTLE_N256);
			default:
				lim = low_power ? TIMER_W'(SETTLE_L128) :
				                  TIMER_W'(SETTLE_N128);
		endcase
		return lim;
	endfunction

	// Register address match on the word offset.
	function automatic logic addr_is(
		input logic [11:0] addr,
		input logic [11:0] ofs
	);
		return addr[11:2] == ofs[11:2];
	endfunction

	// ------------------------------------------------------------------
	// Registers and internal state
	// ------------------------------------------------------------------
	logic [3:0]               ctrl_q;
	logic                     aw_held_q;
	logic                     w_held_q;
	logic [11:0]              awaddr_q;
	logic [31:0]              wdata_q;
	logic [3:0]               wstrb_q;
	logic                     over_acc_q;
	logic                     over_limit_q;
	logic [23:0]              last_result_q;
	logic [31:0]              pend_word_q;
	logic                     pend_q;
	logic [31:0]              shift_q;
	logic [5:0]               bit_cnt_q;
	arso_pkg::arso_state_t    state_q;
	logic                     settled;
	logic                     cfg_restart_q;
	logic                     do_write;
	logic                     sco_rise;
	logic                     load_frame;
	logic [3:0]               ctrl_d;

	// The write happens once both address and data have been taken.
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

	// ------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------
	// Address and data are taken independently in either order; each ready
	// drops while its half is held, which back-pressures the master.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= 12'h000;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_q <= 1'b0;
			end
			s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// Write response; unmapped or read-only offsets answer SLVERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ARSO_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_is(awaddr_q, `ARSO_OFS_CTRL) ?
			                `ARSO_RESP_OKAY : `ARSO_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control register takes byte lane 0 only; the rest read as zero.
	always_comb begin
		ctrl_d = ctrl_q;
		if (do_write && addr_is(awaddr_q, `ARSO_OFS_CTRL) && wstrb_q[0]) begin
			ctrl_d = wdata_q[3:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q        <= `ARSO_CTRL_RESET;
			cfg_restart_q <= 1'b0;
		end else begin
			ctrl_q        <= ctrl_d;
			cfg_restart_q <= do_write && addr_is(awaddr_q, `ARSO_OFS_CTRL);
		end
	end

	// Control outputs are registered copies so they leave from flops.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			front_amp_disable <= 1'b0;
			economy_mode      <= 1'b0;
			ratio_sel_hi      <= 1'b0;
			ratio_sel_lo      <= 1'b0;
		end else begin
			front_amp_disable <= ctrl_d[`ARSO_CTRL_FRONT_AMP_DISABLE];
			economy_mode      <= ctrl_d[`ARSO_CTRL_ECONOMY];
			ratio_sel_hi      <= ctrl_d[`ARSO_CTRL_RATIO_HI];
			ratio_sel_lo      <= ctrl_d[`ARSO_CTRL_RATIO_LO];
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------
	// One read at a time: arready is low while the answer waits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ARSO_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `ARSO_RESP_OKAY;
			if (addr_is(s_axi_araddr, `ARSO_OFS_CTRL)) begin
				s_axi_rdata <= {28'h000_0000, ctrl_q};
			end else if (addr_is(s_axi_araddr, `ARSO_OFS_STATUS)) begin
				s_axi_rdata <= {28'h000_0000, pend_q,
				                state_q == arso_pkg::ARSO_SHIFT,
				                over_limit_q, settled};
			end else if (addr_is(s_axi_araddr, `ARSO_OFS_RESULT)) begin
				s_axi_rdata <= {8'h00, last_result_q};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `ARSO_RESP_SLVERR;
			end
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Filter settling
	// ------------------------------------------------------------------
	// Restart is held while the restart input is low, and a control write
	// restarts it too, since a new ratio or mode refills the filter.
	arso_settle_timer #(
		.TIMER_W (TIMER_W)
	) u_settle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.restart (!filter_restart_n || cfg_restart_q),
		.limit   (settle_limit(ctrl_q[`ARSO_CTRL_ECONOMY],
		                       ctrl_q[`ARSO_CTRL_RATIO_HI:`ARSO_CTRL_RATIO_LO])),
		.settled (settled)
	);

	// ------------------------------------------------------------------
	// Overrange accumulation
	// ------------------------------------------------------------------
	// Samples that overrun in the cycle a result closes are not lost: they
	// are counted into that result, and the accumulator starts clean.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			over_acc_q   <= 1'b0;
			over_limit_q <= 1'b0;
		end else if (result_valid) begin
			over_limit_q <= over_acc_q || sample_over;
			over_acc_q   <= 1'b0;
		end else if (sample_over) begin
			over_acc_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Frame assembly
	// ------------------------------------------------------------------
	// The word is built when the result arrives so that its flags belong to
	// that result; a newer result replaces one that has not started.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_word_q   <= 32'h0000_0000;
			pend_q        <= 1'b0;
			last_result_q <= 24'h00_0000;
		end else if (result_valid) begin
			pend_q        <= 1'b1;
			last_result_q <= result_data;
			pend_word_q   <= {result_data,
			                  settled && !(over_acc_q || sample_over),
			                  over_acc_q || sample_over,
			                  ctrl_q[`ARSO_CTRL_ECONOMY],
			                  ctrl_q[`ARSO_CTRL_RATIO_HI],
			                  ctrl_q[`ARSO_CTRL_RATIO_LO],
			                  3'h0};
		end else if (load_frame) begin
			pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Serial link
	// ------------------------------------------------------------------
	// The shift clock is a toggling flop; every change of data and frame
	// sync is made on the edge that raises it.
	assign sco_rise   = !shift_clock_out;
	assign load_frame = sco_rise && pend_q && !result_valid &&
	                    state_q == arso_pkg::ARSO_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_clock_out <= 1'b0;
		end else begin
			shift_clock_out <= !shift_clock_out;
		end
	end

	// Bit count runs 1..32 inside a frame; frame sync rises on the rising
	// shift edge after the 32nd bit, so it is low for 32 shift periods.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q        <= arso_pkg::ARSO_IDLE;
			shift_q        <= 32'h0000_0000;
			bit_cnt_q      <= 6'h00;
			frame_sync_out <= 1'b1;
			tx_bit_line    <= 1'b0;
		end else if (sco_rise) begin
			case (state_q)
				arso_pkg::ARSO_IDLE: begin
					if (load_frame) begin
						state_q        <= arso_pkg::ARSO_SHIFT;
						frame_sync_out <= 1'b0;
						tx_bit_line    <= pend_word_q[31];
						shift_q        <= {pend_word_q[30:0], 1'b0};
						bit_cnt_q      <= 6'h01;
					end
				end
				arso_pkg::ARSO_SHIFT: begin
					if (bit_cnt_q == 6'(`ARSO_FRAME_BITS)) begin
						state_q        <= arso_pkg::ARSO_IDLE;
						frame_sync_out <= 1'b1;
						tx_bit_line    <= 1'b0;
						bit_cnt_q      <= 6'h00;
					end else begin
						tx_bit_line <= shift_q[31];
						shift_q     <= {shift_q[30:0], 1'b0};
						bit_cnt_q   <= bit_cnt_q + 6'h01;
					end
				end
				default: begin
					state_q <= arso_pkg::ARSO_IDLE;
				end
			endcase
		end
	end

endmodule

// *** verilog/arso_defines.svh ***
// Constants of the serial result framer: register map, field positions,
// reset values and frame geometry.
// Assumes inclusion by bare name from the framer's design files.
`ifndef ARSO_DEFINES_SVH
`define ARSO_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ARSO_OFS_CTRL       12'h000
`define ARSO_OFS_STATUS     12'h004
`define ARSO_OFS_RESULT     12'h008

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define ARSO_CTRL_FRONT_AMP_DISABLE   0
`define ARSO_CTRL_ECONOMY   1
`define ARSO_CTRL_RATIO_LO  2
`define ARSO_CTRL_RATIO_HI  3
`define ARSO_CTRL_RESET     4'h0

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define ARSO_STAT_SETTLED   0
`define ARSO_STAT_OVER      1
`define ARSO_STAT_BUSY      2
`define ARSO_STAT_PENDING   3

// ----------------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------------
`define ARSO_FRAME_BITS     32
`define ARSO_DATA_BITS      24
`define ARSO_STATUS_BITS    5
`define ARSO_PAD_BITS       3

// ----------------------------------------------------------------------
// Filter settling time from restart, in master clock periods
// ----------------------------------------------------------------------
`define ARSO_SETTLE_N64     7128
`define ARSO_SETTLE_N128    13966
`define ARSO_SETTLE_N256    27901
`define ARSO_SETTLE_L64     7282
`define ARSO_SETTLE_L128    14248
`define ARSO_SETTLE_L256    27926

// AXI4-Lite response codes.
`define ARSO_RESP_OKAY      2'h0
`define ARSO_RESP_SLVERR    2'h2

`endif

// *** verilog/arso_pkg.sv ***
// Types shared by the serial result framer.
// Assumes nothing beyond a SystemVerilog compiler.
package arso_pkg;

	// Decimation ratio as carried in the two ratio bits.
	typedef enum logic [1:0] {
		ARSO_RATIO_256 = 2'h0,
		ARSO_RATIO_64  = 2'h1,
		ARSO_RATIO_128 = 2'h2,
		ARSO_RATIO_128B = 2'h3
	} arso_ratio_t;

	// Shifter state.
	typedef enum logic [0:0] {
		ARSO_IDLE,
		ARSO_SHIFT
	} arso_state_t;

endpackage

// *** verilog/arso_settle_timer.sv ***
// Filter settling timer: counts master clocks from a restart and flags
// when the programmed settling time has passed.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps

module arso_settle_timer #(
	parameter int TIMER_W = 16
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               restart,
	input  wire logic [TIMER_W-1:0] limit,
	output logic                    settled
);

	logic [TIMER_W-1:0] count_q;

	// ------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------
	if (TIMER_W < 2) begin : g_bad_width
		$error("arso_settle_timer: TIMER_W too small");
	end

	// Count stops at the limit so that the flag stays up until restart.
	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			count_q <= '0;
			settled <= 1'b0;
		end else if (count_q >= limit) begin
			settled <= 1'b1;
		end else begin
			count_q <= count_q + TIMER_W'(1);
		end
	end

endmodule

// *** sim/arso_host_rx.sv ***
// Host side receiver model for the serial result link.
// Assumes the framer drives shift clock, frame sync and data; it only
// listens and publishes each complete 32-bit word it captured.
`timescale 1ns/10ps

module arso_host_rx (
	input  wire logic        shift_clock_out,
	input  wire logic        frame_sync_out,
	input  wire logic        tx_bit_line,
	output logic [31:0]      rx_word,
	output int               rx_count
);
	// ------------------------------------------------------------------
	// Capture
	// ------------------------------------------------------------------
	logic [31:0] shift_v;
	int          n_bits;

	initial begin
		rx_word = 32'h0;
		rx_count = 0;
		shift_v = 32'h0;
		n_bits = 0;
	end

	// Bits are taken on the falling edge, mid bit, where the line is
	// steady; the model never drives anything back.
	always @(negedge shift_clock_out) begin
		if (!frame_sync_out) begin
			shift_v = {shift_v[30:0], tx_bit_line};
			n_bits++;
			if (n_bits == 32) begin
				rx_word = shift_v;
				rx_count++;
				n_bits = 0;
			end
		end
	end
endmodule

// *** sim/arso_top_checker.sv ***
// Concurrent checks on the ports of the serial result framer.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps

module arso_top_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        result_valid,
	input wire logic        economy_mode,
	input wire logic        ratio_sel_hi,
	input wire logic        ratio_sel_lo,
	input wire logic        shift_clock_out,
	input wire logic        frame_sync_out,
	input wire logic        tx_bit_line
);
	// ------------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------------
	logic [6:0] lo_cnt_q;

	// Counts master clocks spent inside the current frame; the bit slot
	// is half this count, which lets checks address single status bits.
	always_ff @(posedge aclk) begin
		if (!aresetn || frame_sync_out)
			lo_cnt_q <= 7'h0;
		else
			lo_cnt_q <= lo_cnt_q + 7'h1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_sco_half_rate: assert property ($past(aresetn, 2) |->
		shift_clock_out != $past(shift_clock_out)) else $error("sco rate");
	a_frame_len_exact: assert property ($rose(frame_sync_out) |->
		lo_cnt_q == 7'h40) else $error("frame length");
	a_frame_len_max: assert property (lo_cnt_q <= 7'h40)
		else $error("frame too long");
	a_frame_start_due: assert property (result_valid && frame_sync_out |->
		##[1:5] !frame_sync_out) else $error("frame start late");
	a_start_on_rise: assert property ($fell(frame_sync_out) |->
		$rose(shift_clock_out)) else $error("frame start edge");
	a_bit_hold_fall: assert property (!frame_sync_out &&
		!$rose(shift_clock_out) |-> $stable(tx_bit_line))
		else $error("bit moved off rising edge");
	a_idle_line_low: assert property (frame_sync_out |-> !tx_bit_line)
		else $error("data outside frame");
	a_pad_bits_zero: assert property (!frame_sync_out &&
		lo_cnt_q >= 7'h3a |-> !tx_bit_line) else $error("pad bit set");
	a_economy_bit: assert property (!frame_sync_out &&
		lo_cnt_q == 7'h34 |-> tx_bit_line == economy_mode)
		else $error("economy bit");
	a_ratio_bits: assert property (!frame_sync_out &&
		lo_cnt_q == 7'h36 |-> tx_bit_line == ratio_sel_hi ##2
		tx_bit_line == ratio_sel_lo) else $error("ratio bits");
	a_settle_vs_over: assert property (!frame_sync_out &&
		lo_cnt_q == 7'h32 && tx_bit_line |-> !$past(tx_bit_line, 2))
		else $error("settled with overrange");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");

	c_frame_done: cover property ($rose(frame_sync_out));
	c_write_done: cover property (s_axi_bvalid && s_axi_bready);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind arso_top arso_top_checker u_chk (.*);

// *** sim/tb.sv ***
// Self-checking bench for the serial result framer: AXI4-Lite tasks,
// a host receiver model on the link, and word-level comparisons.
// Assumes the framer files and the defines header are compiled first.
`timescale 1ns/10ps
`include "arso_defines.svh"

module tb;
	localparam int SETTLE = 20;

	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, result_valid;
	logic        sample_over, filter_restart_n, front_amp_disable;
	logic        economy_mode, ratio_sel_hi, ratio_sel_lo;
	logic        shift_clock_out, frame_sync_out, tx_bit_line;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rx_word, rd;
	logic [3:0]  s_axi_wstrb, ctrl_v;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [23:0] result_data;
	int          rx_count, n_fail, tests_run, cyc;

	arso_top #(.SETTLE_N64(SETTLE), .SETTLE_N128(SETTLE),
		.SETTLE_N256(SETTLE), .SETTLE_L64(SETTLE), .SETTLE_L128(SETTLE),
		.SETTLE_L256(SETTLE)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.result_valid(result_valid), .result_data(result_data),
		.sample_over(sample_over), .filter_restart_n(filter_restart_n),
		.front_amp_disable(front_amp_disable), .economy_mode(economy_mode),
		.ratio_sel_hi(ratio_sel_hi), .ratio_sel_lo(ratio_sel_lo),
		.shift_clock_out(shift_clock_out), .frame_sync_out(frame_sync_out),
		.tx_bit_line(tx_bit_line));

	arso_host_rx host (.shift_clock_out(shift_clock_out),
		.frame_sync_out(frame_sync_out), .tx_bit_line(tx_bit_line),
		.rx_word(rx_word), .rx_count(rx_count));

	// ------------------------------------------------------------------
	// Clock, timeout and closing report
	// ------------------------------------------------------------------
	always #5 aclk = ~aclk;

	// The run needs about 700 cycles; the ceiling leaves ample margin.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			end_sim();
		end
	end

	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// ------------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------------
	// Both channels are offered together and released as each is taken.
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_t, w_t, b_t;
		aw_t = 0;
		w_t = 0;
		b_t = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_t) begin
			@(posedge aclk);
			if (s_axi_bvalid && aw_t && w_t) begin
				b_t = 1;
				s_axi_bready <= 1'b0;
				chk({30'h0, s_axi_bresp}, {30'h0, er});
			end
			if (!aw_t && s_axi_awready) begin
				aw_t = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_t && s_axi_wready) begin
				w_t = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
	endtask

	task automatic axi_rd(input logic [11:0] a);
		logic ar_t, r_t;
		ar_t = 0;
		r_t = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_t) begin
			@(posedge aclk);
			if (s_axi_rvalid && ar_t) begin
				r_t = 1;
				rd = s_axi_rdata;
				rr = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
			if (!ar_t && s_axi_arready) begin
				ar_t = 1;
				s_axi_arvalid <= 1'b0;
			end
		end
	endtask

	// One result strobe, then the captured word against the frame layout.
	// Odd data puts the overrange in the strobe cycle, even data one cycle
	// ahead, so both ways into the accumulator are exercised.
	task automatic send(input logic [23:0] d, input logic ov,
		input logic st);
		int c0, t;
		c0 = rx_count;
		t = 0;
		@(posedge aclk);
		sample_over <= ov & ~d[0];
		@(posedge aclk);
		result_valid <= 1'b1;
		result_data <= d;
		sample_over <= ov & d[0];
		@(posedge aclk);
		result_valid <= 1'b0;
		sample_over <= 1'b0;
		while (rx_count == c0 && t < 200) begin
			@(posedge aclk);
			t++;
		end
		chk(rx_word, {d, st & ~ov, ov, ctrl_v[1], ctrl_v[3], ctrl_v[2],
			3'h0});
		@(posedge aclk);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	logic [3:0]  ctrl_tbl [4] = '{4'h0, 4'h6, 4'h9, 4'hd};
	logic [23:0] data_tbl [4] = '{24'h7fffff, 24'h800000, 24'h123456,
		24'hedcba9};
	logic        over_tbl [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, result_valid, sample_over} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		result_data = 24'h0;
		filter_restart_n = 1'b1;
		ctrl_v = 4'h0;
		{n_fail, tests_run, cyc} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		chk({ratio_sel_hi, ratio_sel_lo, economy_mode, front_amp_disable}, 0);
		chk({frame_sync_out, tx_bit_line}, 32'h2);
		axi_rd(`ARSO_OFS_CTRL);
		chk(rd, 32'h0);
		axi_rd(12'hffc);
		chk({rd[29:0], rr}, {30'h0, `ARSO_RESP_SLVERR});
		axi_wr(`ARSO_OFS_STATUS, 32'hf, `ARSO_RESP_SLVERR);
		// Each ratio code, economy and amplifier setting, with overrange
		// on alternate results so the flag must also clear again.
		for (int i = 0; i < 4; i++) begin
			ctrl_v = ctrl_tbl[i];
			axi_wr(`ARSO_OFS_CTRL, {28'h0, ctrl_v}, `ARSO_RESP_OKAY);
			#1;
			chk({ratio_sel_hi, ratio_sel_lo, economy_mode, front_amp_disable}, ctrl_v);
			axi_rd(`ARSO_OFS_CTRL);
			chk(rd, {28'h0, ctrl_v});
			repeat (SETTLE + 10) @(posedge aclk);
			send(data_tbl[i], over_tbl[i], 1'b1);
			axi_rd(`ARSO_OFS_RESULT);
			chk(rd, {8'h00, data_tbl[i]});
			axi_rd(`ARSO_OFS_STATUS);
			chk(rd, {30'h0, over_tbl[i], 1'b1});
		end
		// A filter restart must clear the settled flag for a while.
		@(posedge aclk);
		filter_restart_n <= 1'b0;
		repeat (4) @(posedge aclk);
		filter_restart_n <= 1'b1;
		send(24'h000001, 1'b0, 1'b0);
		repeat (SETTLE + 10) @(posedge aclk);
		send(24'hfffffe, 1'b0, 1'b1);
		end_sim();
	end
endmodule
